// ==== irq_level_pkg.sv ====
// constants, field layout and types for the interrupt priority level registers
package irq_level_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_SRC   = 19;
   localparam int NUM_REGS  = 4;
   localparam int REG_W     = 16;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int IDX_W     = 2;
   localparam int FIELD_W   = 2;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_LEVEL_CFG_0 = 2'h0;
   localparam logic [IDX_W-1:0] IDX_LEVEL_CFG_1 = 2'h1;
   localparam logic [IDX_W-1:0] IDX_LEVEL_CFG_2 = 2'h2;
   localparam logic [IDX_W-1:0] IDX_LEVEL_CFG_3 = 2'h3;
   localparam int               ADDR_LSB        = 2;

   // ----------------------------------------------------------------
   // writable bits per register; everything else is reserved, reads 0
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0] WMASK_0 = 16'h0003;
   localparam logic [REG_W-1:0] WMASK_1 = 16'hFFFF;
   localparam logic [REG_W-1:0] WMASK_2 = 16'hC3FF;
   localparam logic [REG_W-1:0] WMASK_3 = 16'hC03F;
   localparam logic [REG_W-1:0] CFG_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // field codes
   // ----------------------------------------------------------------
   localparam logic [FIELD_W-1:0] CODE_OFF  = 2'h0;
   localparam logic [FIELD_W-1:0] LEVEL_ONE = 2'h1;

   // ----------------------------------------------------------------
   // source numbering
   // ----------------------------------------------------------------
   localparam int SRC_DEBUG_STEP          = 0;
   localparam int SRC_FLASH_ERROR         = 1;
   localparam int SRC_FLASH_CMD_DONE      = 2;
   localparam int SRC_FLASH_BUFFERS_EMPTY = 3;
   localparam int SRC_CAN_ERROR           = 4;
   localparam int SRC_CAN_RECEIVE         = 5;
   localparam int SRC_CAN_TRANSMIT        = 6;
   localparam int SRC_CAN_WAKE            = 7;
   localparam int SRC_PORT_D              = 8;
   localparam int SRC_PORT_C              = 9;
   localparam int SRC_PORT_B              = 10;
   localparam int SRC_PORT_A              = 11;
   localparam int SRC_SPI_RX_FULL         = 12;
   localparam int SRC_SPI_TX_EMPTY        = 13;
   localparam int SRC_SERIAL_TX_EMPTY     = 14;
   localparam int SRC_SERIAL_TX_IDLE      = 15;
   localparam int SRC_SERIAL_RX_ERROR     = 16;
   localparam int SRC_SERIAL_RX_FULL      = 17;
   localparam int SRC_TWOWIRE_ERROR       = 18;

   // register index and field lsb of each source, in source order
   localparam int SRC_REG [NUM_SRC] = '{0, 1, 1, 1, 1, 1, 1, 1, 1,
                                        2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
   localparam int SRC_LSB [NUM_SRC] = '{0, 0, 2, 4, 6, 8, 10, 12, 14,
                                        0, 2, 4, 6, 8, 14, 0, 2, 4, 14};

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [NUM_SRC-1:0][FIELD_W-1:0] level_vec_t;
   typedef logic [NUM_SRC-1:0]              src_vec_t;

endpackage : irq_level_pkg

// ==== irq_level_if.sv ====
// carrier between the register file and the per-source level decoder
`timescale 1ns/1ps
interface irq_level_if;
   import irq_level_pkg::*;

   level_vec_t code;
   src_vec_t   req;
   src_vec_t   fwd_valid;
   level_vec_t fwd_level;

   modport regs   (output code, output req, input fwd_valid, input fwd_level);
   modport decode (input code, input req, output fwd_valid, output fwd_level);

endinterface : irq_level_if

// ==== irq_level_decode.sv ====
// per-source decode of priority codes into forwarded requests
`timescale 1ns/1ps
module irq_level_decode (
   irq_level_if.decode lv
);
   import irq_level_pkg::*;

   // ----------------------------------------------------------------
   // one decoder per source
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      // a zero code blocks the request entirely
      assign lv.fwd_valid[i] = lv.req[i] & (lv.code[i] != CODE_OFF);
      if (i == SRC_DEBUG_STEP) begin : g_dbg
         assign lv.fwd_level[i] = lv.code[i];
      end else begin : g_per
         // codes 1..3 map to levels 0..2
         assign lv.fwd_level[i] = lv.code[i] - LEVEL_ONE;
      end
   end

endmodule : irq_level_decode

// ==== irq_level_regs.sv ====
// interrupt priority level registers with apb access and request forwarding
//
// Operation
// - the debug step-counter field sits in bits 1:0 of register 0, code 0 off, 1..3 levels 1..3.
// - every peripheral field decodes 00 as disabled and 01, 10, 11 as levels 0, 1, 2.
// - reset clears every field to 00 so all sources start disabled.
// - register 1 bits 15:14 hold the port D level.
// - register 1 bits 13:12, 11:10, 9:8, 7:6 hold can wake, transmit, receive and error levels.
// - register 1 bits 5:4, 3:2, 1:0 hold flash buffers-empty, command-done and error levels.
// - register 2 bits 15:14 serial tx empty, 9:8 spi tx empty, 7:6 spi rx full.
// - register 2 bits 5:4, 3:2, 1:0 hold port A, B and C levels.
// - register 3 bits 15:14 two-wire error, 5:4, 3:2, 1:0 serial rx full, rx error, tx idle.
`timescale 1ns/1ps
module irq_level_regs (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                clk_en,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [irq_level_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [irq_level_pkg::DATA_W-1:0]    pwdata,
   input  wire logic [irq_level_pkg::DATA_W/8-1:0]  pstrb,
   output logic      [irq_level_pkg::DATA_W-1:0]    prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire irq_level_pkg::src_vec_t             src_req,
   output irq_level_pkg::src_vec_t                  fwd_valid,
   output irq_level_pkg::level_vec_t                fwd_level
);
   import irq_level_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [REG_W-1:0]  cfg_reg   [NUM_REGS];
   logic [REG_W-1:0]  cfg_next  [NUM_REGS];
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic              pready_reg;
   logic              pready_next;
   logic              pslverr_reg;
   logic              pslverr_next;
   src_vec_t          fwd_valid_reg;
   src_vec_t          fwd_valid_next;
   level_vec_t        fwd_level_reg;
   level_vec_t        fwd_level_next;

   logic [REG_W-1:0]  wmask [NUM_REGS];
   logic [IDX_W-1:0]  idx;
   logic              mapped;
   logic              access;

   irq_level_if lv ();

   assign wmask[IDX_LEVEL_CFG_0] = WMASK_0;
   assign wmask[IDX_LEVEL_CFG_1] = WMASK_1;
   assign wmask[IDX_LEVEL_CFG_2] = WMASK_2;
   assign wmask[IDX_LEVEL_CFG_3] = WMASK_3;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign idx    = paddr[ADDR_LSB +: IDX_W];
   // only aligned words of the four indices answer without error
   assign mapped = (paddr[ADDR_W-1:ADDR_LSB+IDX_W] == '0) && (paddr[ADDR_LSB-1:0] == '0);
   assign access = psel & penable;

   // ----------------------------------------------------------------
   // field extraction, one per source
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_field
      assign lv.code[i] = cfg_reg[SRC_REG[i]][SRC_LSB[i] +: FIELD_W];
   end
   assign lv.req = src_req;

   irq_level_decode u_decode (
      .lv (lv)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      cfg_next       = cfg_reg;
      prdata_next    = prdata_reg;
      pready_next    = 1'b0;
      pslverr_next   = pslverr_reg;
      fwd_valid_next = lv.fwd_valid;
      fwd_level_next = lv.fwd_level;
      // one wait state: answer is prepared in the first access cycle
      if (access && !pready_reg) begin
         pready_next  = 1'b1;
         pslverr_next = !mapped;
         if (mapped) begin
            prdata_next = {{(DATA_W-REG_W){1'b0}}, cfg_reg[idx]};
         end else begin
            prdata_next = '0;
         end
      end
      // write lands on the completing edge; reserved bits never store
      if (access && pready_reg && pwrite && mapped) begin
         for (int b = 0; b < REG_W/8; b++) begin
            if (pstrb[b]) begin
               cfg_next[idx][b*8 +: 8] = pwdata[b*8 +: 8] & wmask[idx][b*8 +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers; clk_en low freezes everything, bus included
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            cfg_reg[r] <= CFG_RESET;
         end
         prdata_reg    <= '0;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
         fwd_valid_reg <= '0;
         fwd_level_reg <= '0;
      end else if (clk_en) begin
         cfg_reg       <= cfg_next;
         prdata_reg    <= prdata_next;
         pready_reg    <= pready_next;
         pslverr_reg   <= pslverr_next;
         fwd_valid_reg <= fwd_valid_next;
         fwd_level_reg <= fwd_level_next;
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = pready_reg;
   assign pslverr   = pslverr_reg;
   assign fwd_valid = fwd_valid_reg;
   assign fwd_level = fwd_level_reg;

endmodule : irq_level_regs

// ==== irq_level_asserts.sv ====
// checker for bus answer timing and request forwarding
`timescale 1ns/1ps
module irq_level_asserts (
   input wire logic                                pclk,
   input wire logic                                presetn,
   input wire logic                                clk_en,
   input wire logic                                psel,
   input wire logic                                penable,
   input wire logic [irq_level_pkg::ADDR_W-1:0]    paddr,
   input wire logic [irq_level_pkg::DATA_W-1:0]    prdata,
   input wire logic                                pready,
   input wire logic                                pslverr,
   input wire irq_level_pkg::src_vec_t             src_req,
   input wire irq_level_pkg::src_vec_t             fwd_valid,
   input wire irq_level_pkg::level_vec_t           fwd_level
);
   import irq_level_pkg::*;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   logic bad_level;
   always_comb begin
      bad_level = 1'b0;
      for (int i = 1; i < NUM_SRC; i++)
         bad_level = bad_level | (fwd_valid[i] && fwd_level[i] == 2'h3);
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ((psel && !penable && clk_en) ##1
      (psel && penable && clk_en) [*2] |-> pready) else $error("no answer after one wait");
   a_ready_pulse: assert property (pready && clk_en |=> !pready)
      else $error("ready held too long");
   a_err_unmapped: assert property (pready && (paddr[7:4] != 0 || paddr[1:0] != 0)
      |-> pslverr && prdata == 0) else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && paddr[7:4] == 0 && paddr[1:0] == 0
      |-> !pslverr && prdata[31:16] == 0) else $error("mapped access refused");
   a_fwd_cause: assert property (clk_en |=> (fwd_valid & ~$past(src_req)) == 0)
      else $error("forward without request");
   a_debug_level: assert property (fwd_valid[0] |-> fwd_level[0] != 2'h0)
      else $error("debug level zero");
   a_periph_level: assert property (!bad_level) else $error("peripheral level three");
   a_rdata_hold: assert property (pready && clk_en |=> $stable(prdata))
      else $error("read data not held");
   a_fwd_frozen: assert property (!clk_en |=> $stable(fwd_valid) && $stable(fwd_level))
      else $error("forwarded request moved while frozen");
endmodule : irq_level_asserts

// ==== irq_src_model.sv ====
// behavioural model of the peripheral request sources
`timescale 1ns/1ps
module irq_src_model (
   input  wire logic                     pclk,
   input  wire irq_level_pkg::src_vec_t  want,
   output irq_level_pkg::src_vec_t       src_req
);
   import irq_level_pkg::*;
   // ----------------------------------------------------------------
   // request lines
   // ----------------------------------------------------------------
   // sources hold a level, so a disabled field must mask it every cycle
   initial src_req = '0;
   always @(posedge pclk) src_req <= want;
endmodule : irq_src_model

// ==== tb_top.sv ====
// testbench for the priority level registers
`timescale 1ns/1ps
module tb_top;
   import irq_level_pkg::*;
   // ----------------------------------------------------------------
   // stimulus, reference and checks
   // ----------------------------------------------------------------
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]  paddr = 8'h00, a;
   logic [31:0] pwdata = 32'h0, prdata;
   src_vec_t    want = '0, src_req, fwd_valid, exp_v = '0;
   level_vec_t  fwd_level, exp_l;
   logic [15:0] r = 16'h0027, d, cfg [4] = '{default: 16'h0000};
   logic        clk_en = 1'b1;
   logic [3:0]  pstrb = 4'hF, strb = 4'hF;
   logic [15:0] wv, lane;
   logic [15:0] wm [4] = '{WMASK_0, WMASK_1, WMASK_2, WMASK_3};
   logic [33:0] note [$];
   int          miscompares = 0, checked = 0;
   irq_level_regs irq_level_regs_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_req, .fwd_valid, .fwd_level);
   irq_src_model irq_src_model_i (.pclk, .want, .src_req);
   always #5 pclk = ~pclk;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task automatic cmp(input bit ok, input string m);
      checked++;
      if (!ok) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : cmp
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   // read data only checked on reads; the flag on every transfer
   task automatic chk_bus();
      logic [33:0] n;
      n = note.pop_front();
      cmp(pslverr === n[0], "error flag");
      if (n[33]) cmp(prdata === n[32:1], "read data");
   endtask : chk_bus
   task automatic chk_fwd();
      cmp(fwd_valid === exp_v, "request mask");
      for (int i = 0; i < NUM_SRC; i++)
         if (exp_v[i]) cmp(fwd_level[i] === exp_l[i], "level");
   endtask : chk_fwd
   always @(posedge pclk) begin
      r <= lfsr(r);
      want <= {r[2:0], r};
      if (pready === 1'b1) chk_bus();
      // clock enable low freezes the outputs, so the reference holds as well
      if (clk_en) for (int i = 0; i < NUM_SRC; i++) begin
         exp_v[i] <= src_req[i] && cfg[SRC_REG[i]][SRC_LSB[i] +: 2] != 2'h0;
         exp_l[i] <= cfg[SRC_REG[i]][SRC_LSB[i] +: 2] - 2'(i > 0);
      end
   end
   always @(negedge pclk)
      if (presetn) chk_fwd();
   // leaves the request up so the next call may follow back to back
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [15:0] wd, e);
      int  n;
      logic bad;
      logic [15:0] lm;
      bad = ad[7:4] != 0 || ad[1:0] != 0;
      lm = {{8{strb[1]}}, {8{strb[0]}}};
      note.push_back({!w, 16'h0, e, bad});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {16'h0, wd};
      pstrb <= strb;
      @(posedge pclk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         results();
      end
      if (w && !bad) cfg[ad[3:2]] <= (cfg[ad[3:2]] & ~lm) | (wd & wm[ad[3:2]] & lm);
   endtask : xfer
   task automatic rel();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : rel
   task automatic rst();
      @(posedge pclk) presetn <= 1'b0;
      cfg <= '{default: 16'h0000};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : rst
   task automatic read_all();
      for (int i = 0; i < 4; i++) xfer(0, 8'(4 * i), 0, cfg[i]);
   endtask : read_all
   initial begin
      rst();
      xfer(1, 8'h05, 16'hFFFF, 0);
      xfer(0, 8'h10, 0, 0);
      read_all();
      rel();
      $display("test reset and refusal done");
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 4; i++) xfer(1, 8'(4 * i), {8{2'(c)}} & wm[i], 0);
         for (int i = 0; i < 4; i++) xfer(0, 8'(4 * i), 0, {8{2'(c)}} & wm[i]);
         rel();
         clk_en <= 1'b0;
         repeat (10) @(posedge pclk);
         clk_en <= 1'b1;
         repeat (30) @(posedge pclk);
      end
      $display("test every code done");
      repeat (30) begin
         // random byte lanes; a lane left off keeps its old byte
         a = {4'h0, r[3:2], 2'b00};
         strb = {2'b00, r[5:4]};
         lane = {{8{r[5]}}, {8{r[4]}}};
         wv = r & wm[r[3:2]];
         d = (cfg[r[3:2]] & ~lane) | (wv & lane);
         xfer(1, a, wv, 0);
         xfer(0, a, 0, d);
      end
      rel();
      strb = 4'hF;
      $display("test random config done");
      rst();
      read_all();
      rel();
      $display("test second reset done");
      results();
   end
endmodule : tb_top
bind irq_level_regs irq_level_asserts irq_level_asserts_i (.pclk, .presetn, .clk_en, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .src_req, .fwd_valid, .fwd_level);
